// File: logic/usb_global_irq_address_regs.sv
// usb global event flags, enables, function address and endpoint select
`timescale 1ns/10ps
// Operation
// - reserved bits always read back as zero
// - bus resume while suspended sets wake-up flag
// - wake-up flag interrupts only when enabled
// - end of bus reset sets sticky flag
// - end-of-reset flag interrupts only when enabled
// - frame start pid sets sticky flag
// - frame-start flag interrupts only when enabled
// - 3 ms idle J sets suspend flag
// - suspend flag interrupts only when enabled
// - clearing suspend flag disables usb pads
// - enables reset to 0x10
// - address bit 7 enables the function
// - address field zero on reset, bus reset
// - endpoint select steers per-endpoint register access
// - address-enable clear answers at address 0
// - 32 bit-time SE0 is bus reset, clears address-enable
module usb_global_irq_address_regs (
  input wire logic core_clk,
  input wire logic rst,
  input usb_glb_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input usb_glb_pkg::line_evt_s line_raw,
  output logic usb_irq,
  output logic usb_pads_en,
  output logic function_enable,
  output logic [6:0] function_address_value,
  output logic [3:0] endpoint_select_field,
  output logic bus_reset_active
);
  import usb_glb_pkg::*;

  line_evt_s line;
  logic idle_reached;
  logic se0_reached;
  logic [7:0] flags_q, flags_d;
  logic [7:0] enables_q, enables_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] epsel_q, epsel_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic idle_seen_q, idle_seen_d;
  logic reset_seen_q, reset_seen_d;
  logic suspended_q, suspended_d;
  logic pads_q, pads_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] set_ev;
  logic wake_ev;
  logic eor_ev;
  logic susp_ev;

  function automatic logic is_wr(input sfr_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  usb_line_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .raw(line_raw),
    .synced(line)
  );

  usb_idle_timer #(.LIMIT(SUSPEND_CYCLES)) u_idle (
    .core_clk(core_clk),
    .rst(rst),
    .cond(line.line_j),
    .reached(idle_reached)
  );

  usb_idle_timer #(.LIMIT(BUS_RESET_CYCLES)) u_se0 (
    .core_clk(core_clk),
    .rst(rst),
    .cond(line.line_se0),
    .reached(se0_reached)
  );

  // line event detection
  always_comb begin
    susp_ev = idle_reached && !idle_seen_q;
    eor_ev = reset_seen_q && !line.line_se0;
    // own upstream resume must not look like a host wake-up
    wake_ev = suspended_q && !line.line_j && !line.resume_sending;
    set_ev = '0;
    set_ev[BIT_SUSPEND] = susp_ev;
    set_ev[BIT_EOR] = eor_ev;
    set_ev[BIT_SOF] = line.sof_pid;
    set_ev[BIT_WAKEUP] = wake_ev;
    idle_seen_d = idle_reached;
    reset_seen_d = se0_reached ? 1'b1 : (line.line_se0 ? reset_seen_q : 1'b0);
    suspended_d = suspended_q;
    if (susp_ev) begin
      suspended_d = 1'b1;
    end else if (wake_ev || se0_reached) begin
      suspended_d = 1'b0;
    end
  end

  // register file next state
  always_comb begin
    flags_d = flags_q;
    enables_d = enables_q;
    addr_d = addr_q;
    epsel_d = epsel_q;
    ctrl_d = ctrl_q;
    pads_d = pads_q;
    if (is_wr(sfr_req, OFS_EVENT_FLAGS)) begin
      // only zeros take effect
      flags_d = flags_q & sfr_req.wdata;
      if (flags_q[BIT_SUSPEND] && !sfr_req.wdata[BIT_SUSPEND]) begin
        pads_d = 1'b0;
      end
    end
    flags_d = (flags_d | set_ev) & EVENT_MASK;
    if (susp_ev || wake_ev || se0_reached) begin
      pads_d = 1'b1;
    end
    if (is_wr(sfr_req, OFS_EVENT_ENABLES)) begin
      enables_d = sfr_req.wdata & EVENT_MASK;
    end
    if (is_wr(sfr_req, OFS_FUNC_ADDRESS)) begin
      addr_d = sfr_req.wdata;
    end
    if (is_wr(sfr_req, OFS_EP_SELECT)) begin
      epsel_d = sfr_req.wdata & EP_SEL_MASK;
    end
    if (is_wr(sfr_req, OFS_GLOBAL_CONTROL)) begin
      ctrl_d = sfr_req.wdata & CTRL_MASK;
    end
    if (se0_reached) begin
      addr_d[6:0] = 7'h00;
      ctrl_d[BIT_ADDR_EN] = 1'b0;
    end
  end

  // read mux, data registered
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        OFS_EVENT_FLAGS: rdata_d = flags_q & EVENT_MASK;
        OFS_EVENT_ENABLES: rdata_d = enables_q & EVENT_MASK;
        OFS_FUNC_ADDRESS: rdata_d = addr_q;
        OFS_EP_SELECT: rdata_d = epsel_q & EP_SEL_MASK;
        OFS_GLOBAL_CONTROL: rdata_d = ctrl_q & CTRL_MASK;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_q <= RST_EVENT_FLAGS;
      enables_q <= RST_EVENT_ENABLES;
      addr_q <= RST_FUNC_ADDRESS;
      epsel_q <= RST_EP_SELECT;
      ctrl_q <= RST_CONTROL;
      idle_seen_q <= 1'b0;
      reset_seen_q <= 1'b0;
      suspended_q <= 1'b0;
      pads_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
      enables_q <= enables_d;
      addr_q <= addr_d;
      epsel_q <= epsel_d;
      ctrl_q <= ctrl_d;
      idle_seen_q <= idle_seen_d;
      reset_seen_q <= reset_seen_d;
      suspended_q <= suspended_d;
      pads_q <= pads_d;
      rdata_q <= rdata_d;
    end
  end

  assign usb_irq = |(flags_q & enables_q & EVENT_MASK);
  assign sfr_rdata = rdata_q;
  assign sfr_hit = sfr_req.addr == OFS_EVENT_FLAGS || sfr_req.addr == OFS_EVENT_ENABLES ||
    sfr_req.addr == OFS_FUNC_ADDRESS || sfr_req.addr == OFS_EP_SELECT ||
    sfr_req.addr == OFS_GLOBAL_CONTROL;
  assign usb_pads_en = pads_q;
  assign function_enable = addr_q[BIT_FEN];
  // default address 0 until firmware enables the programmed one
  assign function_address_value = ctrl_q[BIT_ADDR_EN] ? addr_q[6:0] : 7'h00;
  assign endpoint_select_field = epsel_q[3:0];
  assign bus_reset_active = reset_seen_q;

  // separate run-length count of synced se0, so the bus reset length check
  // does not lean on the timer that it watches
  localparam logic [7:0] SE0_RUN_MIN = 8'(BUS_RESET_CYCLES);
  logic [7:0] se0_run_q, se0_run_d;

  always_comb begin
    se0_run_d = 8'h00;
    if (line.line_se0) begin
      se0_run_d = (se0_run_q == 8'hFF) ? se0_run_q : se0_run_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      se0_run_q <= 8'h00;
    end else begin
      se0_run_q <= se0_run_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_clear_write(int b);
    sfr_req.wr && sfr_req.addr == OFS_EVENT_FLAGS && !sfr_req.wdata[b];
  endsequence

  chk_sof_set_wins: assert property (line.sof_pid |=> flags_q[BIT_SOF])
    else $error("frame start flag not set");
  chk_eor_sticky: assert property (eor_ev |=> flags_q[BIT_EOR] [*2]
      or (flags_q[BIT_EOR] ##1 $fell(flags_q[BIT_EOR])))
    else $error("end of reset flag lost");
  chk_flag_clear: assert property (s_clear_write(BIT_SOF) and !line.sof_pid
      |=> !flags_q[BIT_SOF])
    else $error("flag not cleared by zero write");
  chk_irq_gate: assert property (usb_irq == |(flags_q & enables_q))
    else $error("interrupt not flag and enable");
  chk_wake_en: assert property (flags_q[BIT_WAKEUP] && !enables_q[BIT_WAKEUP]
      && !(|(flags_q & enables_q & 8'h19)) |-> !usb_irq)
    else $error("wake-up irq while disabled");
  chk_reserved_zero: assert property ((flags_q & ~EVENT_MASK) == 8'h00
      && (epsel_q & ~EP_SEL_MASK) == 8'h00)
    else $error("reserved bits set");
  chk_addr_bus_reset: assert property (se0_reached |=> addr_q[6:0] == 7'h00
      && !ctrl_q[BIT_ADDR_EN])
    else $error("bus reset did not clear address");
  chk_default_addr: assert property (!ctrl_q[BIT_ADDR_EN] |-> function_address_value == 7'h00)
    else $error("non default address while disabled");
  chk_pads_off: assert property (s_clear_write(BIT_SUSPEND) and flags_q[BIT_SUSPEND]
      and !susp_ev and !wake_ev and !se0_reached |=> !usb_pads_en)
    else $error("pads not disabled");
  chk_enable_reset: assert property ($fell(rst) |-> enables_q == 8'h10)
    else $error("enable reset value wrong");

  // line event and register access checks
  sequence s_host_resume;
    suspended_q && !line.line_j && !line.resume_sending;
  endsequence

  sequence s_bus_reset_end;
    bus_reset_active && line.line_se0 ##1 !line.line_se0;
  endsequence

  chk_wake_set: assert property (s_host_resume |=> flags_q[BIT_WAKEUP])
    else $error("host resume did not set wake-up flag");
  chk_wake_cause: assert property ($rose(flags_q[BIT_WAKEUP]) |-> $past(suspended_q)
      && !$past(line.line_j) && !$past(line.resume_sending))
    else $error("wake-up flag set without host resume");
  chk_eor_set: assert property (s_bus_reset_end |=> flags_q[BIT_EOR])
    else $error("end of bus reset not flagged");
  chk_susp_set: assert property ($rose(idle_reached) |=> flags_q[BIT_SUSPEND])
    else $error("idle bus did not set suspend flag");
  chk_susp_cause: assert property ($rose(flags_q[BIT_SUSPEND]) |-> $past(idle_reached))
    else $error("suspend flag set before idle time");
  chk_eor_gate: assert property (flags_q[BIT_EOR] && !enables_q[BIT_EOR]
      && !(|(flags_q & enables_q & 8'h29)) |-> !usb_irq)
    else $error("end-of-reset irq while disabled");
  chk_sof_gate: assert property (flags_q[BIT_SOF] && !enables_q[BIT_SOF]
      && !(|(flags_q & enables_q & 8'h31)) |-> !usb_irq)
    else $error("frame start irq while disabled");
  chk_susp_gate: assert property (flags_q[BIT_SUSPEND] && !enables_q[BIT_SUSPEND]
      && !(|(flags_q & enables_q & 8'h38)) |-> !usb_irq)
    else $error("suspend irq while disabled");
  chk_fen_write: assert property (is_wr(sfr_req, OFS_FUNC_ADDRESS)
      |=> function_enable == $past(sfr_req.wdata[BIT_FEN]))
    else $error("function enable does not follow write");
  chk_epsel_write: assert property (is_wr(sfr_req, OFS_EP_SELECT)
      |=> endpoint_select_field == $past(sfr_req.wdata[3:0]))
    else $error("endpoint select does not follow write");
  chk_en_write: assert property (is_wr(sfr_req, OFS_EVENT_ENABLES)
      |=> enables_q == ($past(sfr_req.wdata) & EVENT_MASK))
    else $error("enable write kept reserved bits");
  chk_flags_read: assert property (sfr_req.rd && sfr_req.addr == OFS_EVENT_FLAGS
      |=> (sfr_rdata & ~EVENT_MASK) == 8'h00)
    else $error("reserved flag bits read as one");
  chk_enables_read: assert property (sfr_req.rd && sfr_req.addr == OFS_EVENT_ENABLES
      |=> (sfr_rdata & ~EVENT_MASK) == 8'h00)
    else $error("reserved enable bits read as one");
  chk_epsel_read: assert property (sfr_req.rd && sfr_req.addr == OFS_EP_SELECT
      |=> (sfr_rdata & ~EP_SEL_MASK) == 8'h00)
    else $error("reserved endpoint select bits read as one");
  chk_pads_back: assert property (susp_ev || wake_ev || se0_reached |=> usb_pads_en)
    else $error("pads not re-enabled by line event");
  chk_bus_reset_len: assert property (se0_reached == (se0_run_q >= SE0_RUN_MIN))
    else $error("bus reset length wrong");
  chk_reset_clears_en: assert property ($rose(bus_reset_active) |-> $past(se0_reached)
      && !ctrl_q[BIT_ADDR_EN])
    else $error("bus reset did not clear address enable");
endmodule

// File: common/usb_glb_pkg.sv
// shared constants and carriers for the usb global register bank
package usb_glb_pkg;
  // sfr offsets
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'hBD;
  localparam logic [7:0] OFS_EVENT_ENABLES = 8'hBE;
  localparam logic [7:0] OFS_FUNC_ADDRESS = 8'hC6;
  localparam logic [7:0] OFS_EP_SELECT = 8'hC7;
  localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'hBC;
  // event flag / enable, function enable and address enable bit positions
  localparam int BIT_WAKEUP = 5;
  localparam int BIT_EOR = 4;
  localparam int BIT_SOF = 3;
  localparam int BIT_SUSPEND = 0;
  localparam int BIT_FEN = 7;
  localparam int BIT_ADDR_EN = 0;
  // implemented bit masks; everything else reads zero
  localparam logic [7:0] EVENT_MASK = 8'h39;
  localparam logic [7:0] EP_SEL_MASK = 8'h0F;
  localparam logic [7:0] CTRL_MASK = 8'h01;
  // reset values
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_EVENT_ENABLES = 8'h10;
  localparam logic [7:0] RST_FUNC_ADDRESS = 8'h00;
  localparam logic [7:0] RST_EP_SELECT = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // timing at 10 MHz core clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUSPEND_IDLE_US = 3000;
  localparam int SUSPEND_CYCLES = (SUSPEND_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_TIME_PS = 83333;
  localparam int BUS_RESET_BITS = 32;
  localparam int BUS_RESET_CYCLES =
    (BUS_RESET_BITS * BIT_TIME_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
  localparam int IDLE_CNT_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic line_j;
    logic line_se0;
    logic sof_pid;
    logic resume_sending;
  } line_evt_s;
endpackage

// File: logic/usb_idle_timer.sv
// counts consecutive cycles a line condition holds and flags reaching a limit
`timescale 1ns/10ps
module usb_idle_timer #(
  parameter int LIMIT = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cond,
  output logic reached
);
  import usb_glb_pkg::*;
  logic [IDLE_CNT_W-1:0] cnt_q;
  logic [IDLE_CNT_W-1:0] cnt_d;
  localparam logic [IDLE_CNT_W-1:0] LIM = IDLE_CNT_W'(LIMIT);

  always_comb begin
    cnt_d = cnt_q;
    if (!cond) begin
      cnt_d = '0;
    end else if (cnt_q != LIM) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign reached = (cnt_q == LIM);
endmodule

// File: logic/usb_line_sync.sv
// two-flop synchroniser for the line status inputs
`timescale 1ns/10ps
module usb_line_sync (
  input wire logic core_clk,
  input wire logic rst,
  input usb_glb_pkg::line_evt_s raw,
  output usb_glb_pkg::line_evt_s synced
);
  import usb_glb_pkg::*;
  line_evt_s meta_q;
  line_evt_s sync_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;
endmodule

// File: test/usb_line_model.sv
// behavioural driver of the usb line status seen by the register bank
`timescale 1ns/10ps
module usb_line_model (
  input wire logic core_clk,
  output usb_glb_pkg::line_evt_s line_raw
);
  import usb_glb_pkg::*;
  // bus starts busy (not J, not se0) so suspend timing starts only on request
  initial line_raw = '0;
  // waits an edge first so two calls never land in one time step
  task automatic set_line(input logic j, input logic se0, input logic resume);
    @(posedge core_clk);
    #1;
    line_raw.line_j = j;
    line_raw.line_se0 = se0;
    line_raw.resume_sending = resume;
  endtask
  task automatic hold(input logic j, input logic se0, input int n);
    set_line(j, se0, 1'b0);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sof();
    @(posedge core_clk);
    #1;
    line_raw.sof_pid = 1'b1;
    @(posedge core_clk);
    #1;
    line_raw.sof_pid = 1'b0;
  endtask
endmodule

// File: test/usb_global_irq_address_regs_test.sv
// randomised register and line-event test of the usb global register bank
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module usb_global_irq_address_regs_test;
  import usb_glb_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  sfr_req_s sfr_req = '0;
  line_evt_s line_raw;
  logic [7:0] sfr_rdata;
  logic sfr_hit, usb_irq, usb_pads_en, function_enable, bus_reset_active;
  logic [6:0] function_address_value;
  logic [3:0] endpoint_select_field, e;
  logic [7:0] rd_val, v;
  logic hit_val;
  int errors = 0;
  int cmp_count = 0;
  int n;
  always #50 core_clk = ~core_clk;
  usb_line_model LINE (.core_clk(core_clk), .line_raw(line_raw));
  usb_global_irq_address_regs DUT (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .line_raw(line_raw), .usb_irq(usb_irq),
    .usb_pads_en(usb_pads_en), .function_enable(function_enable),
    .function_address_value(function_address_value),
    .endpoint_select_field(endpoint_select_field), .bus_reset_active(bus_reset_active));
  function automatic logic exp_irq(input logic [7:0] f, input logic [7:0] en);
    return |(f & en & EVENT_MASK);
  endfunction
  function automatic logic exp_hit(input logic [7:0] a);
    return a == OFS_EVENT_FLAGS || a == OFS_EVENT_ENABLES || a == OFS_FUNC_ADDRESS ||
      a == OFS_EP_SELECT || a == OFS_GLOBAL_CONTROL;
  endfunction
  task automatic step(input int k = 1);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // each access is followed by an idle cycle so the strobe never re-asserts in one step
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    sfr_req = '0;
    step();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    hit_val = sfr_hit;
    sfr_req = '0;
    rd_val = sfr_rdata;
    step();
    `CHK(rd_val, exp)
    `CHK(hit_val, exp_hit(a))
  endtask
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #5_000_000;
    errors++;
    close_out();
  end
  initial begin
    n = $urandom(99);
    step(12);
    rst = 1'b0;
    rd_chk(OFS_EVENT_FLAGS, 8'h00);
    rd_chk(OFS_EVENT_ENABLES, 8'h10);
    rd_chk(OFS_FUNC_ADDRESS, 8'h00);
    rd_chk(8'hC8, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) | 8'h01;
      e = 4'($urandom_range(6));
      sfr_wr(OFS_EVENT_ENABLES, v & EVENT_MASK);
      rd_chk(OFS_EVENT_ENABLES, v & EVENT_MASK);
      sfr_wr(OFS_FUNC_ADDRESS, v);
      rd_chk(OFS_FUNC_ADDRESS, v);
      `CHK(function_enable, v[7])
      `CHK(function_address_value, 7'h00)
      sfr_wr(OFS_EP_SELECT, {4'h0, e});
      `CHK(endpoint_select_field, e)
    end
    // deliberate reserved-bit writes must still read back as zero
    sfr_wr(OFS_EVENT_ENABLES, 8'hFF);
    rd_chk(OFS_EVENT_ENABLES, 8'h39);
    sfr_wr(OFS_EP_SELECT, 8'hF6);
    rd_chk(OFS_EP_SELECT, 8'h06);
    sfr_wr(OFS_GLOBAL_CONTROL, 8'h01);
    `CHK(function_address_value, v[6:0])
    $display("test register access done");
    sfr_wr(OFS_EVENT_ENABLES, 8'h00);
    LINE.sof();
    step(4);
    rd_chk(OFS_EVENT_FLAGS, 8'h08);
    `CHK(usb_irq, exp_irq(8'h08, 8'h00))
    sfr_wr(OFS_EVENT_ENABLES, 8'h08);
    `CHK(usb_irq, exp_irq(8'h08, 8'h08))
    sfr_wr(OFS_EVENT_FLAGS, 8'hFF);
    rd_chk(OFS_EVENT_FLAGS, 8'h08);
    sfr_wr(OFS_EVENT_FLAGS, 8'hF7);
    rd_chk(OFS_EVENT_FLAGS, 8'h00);
    $display("test frame start done");
    LINE.hold(1'b0, 1'b1, 40);
    `CHK(bus_reset_active, 1'b1)
    `CHK(function_address_value, 7'h00)
    LINE.hold(1'b0, 1'b0, 4);
    rd_chk(OFS_GLOBAL_CONTROL, 8'h00);
    rd_chk(OFS_FUNC_ADDRESS, {v[7], 7'h00});
    rd_chk(OFS_EVENT_FLAGS, 8'h10);
    `CHK(usb_irq, 1'b0)
    sfr_wr(OFS_EVENT_ENABLES, 8'h10);
    `CHK(usb_irq, 1'b1)
    sfr_wr(OFS_EVENT_FLAGS, 8'hEF);
    $display("test bus reset done");
    sfr_wr(OFS_EVENT_ENABLES, 8'h01);
    LINE.set_line(1'b1, 1'b0, 1'b0);
    n = 0;
    while (usb_irq !== 1'b1 && n < 31000) begin
      step();
      n++;
    end
    `CHK(n >= SUSPEND_CYCLES - 2 && n < SUSPEND_CYCLES + 8, 1'b1)
    rd_chk(OFS_EVENT_FLAGS, 8'h01);
    sfr_wr(OFS_EVENT_ENABLES, 8'h00);
    `CHK(usb_irq, 1'b0)
    sfr_wr(OFS_EVENT_FLAGS, 8'hFE);
    `CHK(usb_pads_en, 1'b0)
    LINE.set_line(1'b0, 1'b0, 1'b1);
    step(10);
    rd_chk(OFS_EVENT_FLAGS, 8'h00);
    LINE.set_line(1'b0, 1'b0, 1'b0);
    step(5);
    rd_chk(OFS_EVENT_FLAGS, 8'h20);
    `CHK(usb_pads_en, 1'b1)
    `CHK(usb_irq, 1'b0)
    sfr_wr(OFS_EVENT_ENABLES, 8'h20);
    `CHK(usb_irq, 1'b1)
    // usb pads count as re-enabled here before the flag is cleared
    sfr_wr(OFS_EVENT_FLAGS, 8'hDF);
    `CHK(usb_irq, 1'b0)
    $display("test suspend and wake done");
    sfr_wr(OFS_EP_SELECT, 8'h05);
    sfr_wr(OFS_EVENT_ENABLES, 8'h29);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    rd_chk(OFS_EVENT_ENABLES, RST_EVENT_ENABLES);
    rd_chk(OFS_FUNC_ADDRESS, RST_FUNC_ADDRESS);
    rd_chk(OFS_EP_SELECT, RST_EP_SELECT);
    `CHK(function_enable, 1'b0)
    `CHK(usb_pads_en, 1'b1)
    $display("test mid-run reset done");
    close_out();
  end
endmodule
